//--- core/cmpf_regs.svh
// Register offsets, field positions, reset values and timing counts of
// the comparator control and filter block.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
`ifndef CMPF_REGS_SVH
`define CMPF_REGS_SVH

// Byte offsets
`define CMPF_OFF_CTRL        5'h00
`define CMPF_OFF_FILT        5'h04
`define CMPF_OFF_IRQ_STAT    5'h08
`define CMPF_OFF_IRQ_EN      5'h0C
`define CMPF_OFF_IRQ_CLR     5'h10

// Control register fields
`define CMPF_CTRL_ON         15
`define CMPF_CTRL_PIN_EN     14
`define CMPF_CTRL_INVERT     13
`define CMPF_CTRL_AMP        10
`define CMPF_CTRL_EVT        9
`define CMPF_CTRL_RESULT     8
`define CMPF_CTRL_EVENT_POLARITY_HI   7
`define CMPF_CTRL_EVENT_POLARITY_LO   6
`define CMPF_CTRL_REF        4
`define CMPF_CTRL_CH_HI      1
`define CMPF_CTRL_CH_LO      0
`define CMPF_CTRL_WMASK      16'hE4D3
`define CMPF_CTRL_RMASK      16'hE6D3
`define CMPF_CTRL_RESET      16'h0000

// Filter register fields
`define CMPF_FILT_SEL_HI     6
`define CMPF_FILT_SEL_LO     4
`define CMPF_FILT_EN         3
`define CMPF_FILT_DIV_HI     2
`define CMPF_FILT_DIV_LO     0
`define CMPF_FILT_WMASK      16'h007F
`define CMPF_FILT_RESET      16'h0000

// Interrupt status bits
`define CMPF_IRQ_EVENT       0
`define CMPF_IRQ_WIDTH       1

// Filter: samples that must agree before the output moves
`define CMPF_FILT_SAMPLES    3'h3

`endif

//--- core/cmpf_pkg.sv
// Types of the comparator control and filter block.
// Assumes the constants header is compiled alongside.
package cmpf_pkg;

  // Filter sample clock sources
  typedef enum logic [2:0] {
    CMPF_CLK_PERIPH  = 3'h0,
    CMPF_CLK_OSC     = 3'h1,
    CMPF_CLK_SYNC    = 3'h2,
    CMPF_CLK_RESVD   = 3'h3,
    CMPF_CLK_TIMER2  = 3'h4,
    CMPF_CLK_TIMER3  = 3'h5,
    CMPF_CLK_TIMER4  = 3'h6,
    CMPF_CLK_TIMER5  = 3'h7
  } cmpf_clk_sel_e;

  // Event polarity choices
  typedef enum logic [1:0] {
    CMPF_EV_NONE = 2'h0,
    CMPF_EV_RISE = 2'h1,
    CMPF_EV_FALL = 2'h2,
    CMPF_EV_BOTH = 2'h3
  } cmpf_event_polarity_e;

  // AXI write channel states, Gray along the usual path
  typedef enum logic [1:0] {
    CMPF_WR_IDLE = 2'h0,
    CMPF_WR_RESP = 2'h1
  } cmpf_wr_e;

endpackage : cmpf_pkg

//--- core/cmpf_sync.sv
// Two-flop synchroniser for a single level from outside the clock domain.
// Assumes a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module cmpf_sync (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);

  typedef struct packed {
    logic meta;
    logic sync;
  } cmpf_sync_s;

  cmpf_sync_s st_q;
  cmpf_sync_s st_d;

  // Next state: first flop feeds only the second
  always_comb
  begin
    st_d.meta = async_i;
    st_d.sync = st_q.meta;
  end

  // State register
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sync_o = st_q.sync;

endmodule // cmpf_sync

`default_nettype wire

//--- core/cmpf_filter.sv
// Digital consecutive-sample filter for the comparator result.
// Assumes sample_tick_i is a one-cycle pulse on clock_i.
`timescale 1ns/1ps
`default_nettype none
`include "cmpf_regs.svh"

module cmpf_filter (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  input  wire logic sample_tick_i,
  input  wire logic raw_i,
  output logic      filt_o
);

  typedef struct packed {
    logic       out;
    logic [2:0] cnt;
  } cmpf_filter_s;

  cmpf_filter_s st_q;
  cmpf_filter_s st_d;

  // Enabled, output moves only after enough agreeing samples; disabled, it follows the input
  always_comb
  begin
    st_d = st_q;
    if (!enable_i)
    begin
      st_d.out = raw_i;
      st_d.cnt = 3'h0;
    end
    else if (sample_tick_i)
    begin
      if (raw_i == st_q.out)
        st_d.cnt = 3'h0;
      else if (st_q.cnt == `CMPF_FILT_SAMPLES - 3'h1)
      begin
        st_d.out = raw_i;
        st_d.cnt = 3'h0;
      end
      else
        st_d.cnt = st_q.cnt + 3'h1;
    end
  end

  // State register
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign filt_o = st_q.out;

endmodule // cmpf_filter

`default_nettype wire

//--- core/cmpf_top.sv
// Comparator control and filter: control registers over AXI4-Lite,
// input multiplexer selects, result polarity, event flag, pin enable,
// digital output filter with selectable, divided sample clock.
// Assumes the analog comparator core sits outside; its raw result and the
// sample-clock sources arrive asynchronously and are synchronised here.
// Assumes a master with at most one write and one read outstanding.
//
// Functional notes
// - The unit runs only while the enable bit in bit 15 of control is one.
// - The result reaches the output pin only while the pin drive enable bit is set.
// - In amplifier mode the result pin output is never made available.
// - The reference select routes the positive input to the internal reference or the pin.
// - Channel select routes the negative input to amp outputs three, two, one or the pin.
// - Filter clock select picks timers five to two, reserved, pwm sync, oscillator, peripheral.
// - A selected input that the package lacks is driven from ground.
// - Unimplemented bits ignore writes and read as zero.
`timescale 1ns/1ps
`default_nettype none
`include "cmpf_regs.svh"

module cmpf_top (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // AXI4-Lite slave
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog side
  input  wire logic        raw_compare_i,
  input  wire logic [3:0]  input_present_i,
  input  wire logic        timer_two_clock_i,
  input  wire logic        timer_three_clock_i,
  input  wire logic        timer_four_clock_i,
  input  wire logic        timer_five_clock_i,
  input  wire logic        pwm_sync_output_i,
  input  wire logic        oscillator_clock_i,
  input  wire logic        peripheral_clock_i,
  output logic             unit_on_o,
  output logic             amplifier_select_o,
  output logic             positive_is_reference_o,
  output logic             positive_grounded_o,
  output logic [1:0]       negative_channel_select_o,
  output logic             negative_grounded_o,
  output logic             result_output_pin_o,
  output logic             result_output_pin_oe_n_o,
  output logic             irq_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [15:0]           ctrl;
    logic [15:0]           filt;
    logic [`CMPF_IRQ_WIDTH-1:0] stat;
    logic [`CMPF_IRQ_WIDTH-1:0] ien;
    cmpf_pkg::cmpf_wr_e    wst;
    logic                  aw_got;
    logic                  w_got;
    logic [4:0]            awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [1:0]            bresp;
    logic                  clk_prev;
    logic [2:0]            sel_prev;
    logic [6:0]            div_cnt;
    logic                  result_prev;
    logic                  pin;
  } cmpf_top_s;

  cmpf_top_s st_q;
  cmpf_top_s st_d;

  // Internal nets
  logic raw_sync;
  logic src_sync [8];
  logic sample_src;
  logic src_rise;
  logic sample_tick;
  logic filtered;
  logic result;
  logic event_hit;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [7:0] div_limit;

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // Index equals the filter clock select code; slot three stays low
  logic [7:0] src_async;
  assign src_async = {timer_five_clock_i, timer_four_clock_i, timer_three_clock_i,
                      timer_two_clock_i, 1'b0, pwm_sync_output_i,
                      oscillator_clock_i, peripheral_clock_i};

  cmpf_sync u_sync_raw (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (raw_compare_i),
    .sync_o  (raw_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_src
      cmpf_sync u_sync_src (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i (src_async[gi]),
        .sync_o  (src_sync[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Filter clock select and divider
  // ==========================================================================
  // Reserved code yields a stuck-low source, so no samples
  always_comb
  begin
    sample_src = src_sync[st_q.filt[`CMPF_FILT_SEL_HI:`CMPF_FILT_SEL_LO]];
  end

  // Skip the first cycle after a source change: the stored level is the old source's
  assign src_rise   = sample_src & ~st_q.clk_prev
                    & (st_q.sel_prev == st_q.filt[`CMPF_FILT_SEL_HI:`CMPF_FILT_SEL_LO]);
  // Divide by 2^code: one tick per div_limit source edges
  assign div_limit  = 8'h01 << st_q.filt[`CMPF_FILT_DIV_HI:`CMPF_FILT_DIV_LO];
  // Compare with >= so that a smaller ratio written mid-count cannot leave the
  // counter above its new limit, which would starve the filter for a full wrap
  assign sample_tick = src_rise
                     && ({1'b0, st_q.div_cnt} >= div_limit - 8'h01);

  cmpf_filter u_filter (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .enable_i      (st_q.filt[`CMPF_FILT_EN]),
    .sample_tick_i (sample_tick),
    .raw_i         (raw_sync),
    .filt_o        (filtered)
  );

  // ==========================================================================
  // Result, event detection and pin
  // ==========================================================================
  // Disabled unit holds result low
  assign result = st_q.ctrl[`CMPF_CTRL_ON]
                & (filtered ^ st_q.ctrl[`CMPF_CTRL_INVERT]);

  // Event edge per polarity; a set flag masks new triggers
  always_comb
  begin
    case (cmpf_pkg::cmpf_event_polarity_e'(st_q.ctrl[`CMPF_CTRL_EVENT_POLARITY_HI:`CMPF_CTRL_EVENT_POLARITY_LO]))
      cmpf_pkg::CMPF_EV_RISE: event_hit = result & ~st_q.result_prev;
      cmpf_pkg::CMPF_EV_FALL: event_hit = ~result & st_q.result_prev;
      cmpf_pkg::CMPF_EV_BOTH: event_hit = result ^ st_q.result_prev;
      default:                event_hit = 1'b0;
    endcase
    event_hit = event_hit & ~st_q.ctrl[`CMPF_CTRL_EVT];
  end

  // ==========================================================================
  // Register read mux
  // ==========================================================================
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      // Control reads the writable bits, the event flag and the live result
      `CMPF_OFF_CTRL:     rd_word[15:0] = (st_q.ctrl & `CMPF_CTRL_RMASK)
                                          | {7'h00, result, 8'h00};
      `CMPF_OFF_FILT:     rd_word[15:0] = st_q.filt & `CMPF_FILT_WMASK;
      `CMPF_OFF_IRQ_STAT: rd_word[`CMPF_IRQ_WIDTH-1:0] = st_q.stat;
      `CMPF_OFF_IRQ_EN:   rd_word[`CMPF_IRQ_WIDTH-1:0] = st_q.ien;
      `CMPF_OFF_IRQ_CLR:  rd_word = 32'h0000_0000;
      // Unmapped offsets answer with an error
      default:            rd_ok = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    st_d = st_q;
    // Source level, source choice and result of this cycle, for edge detection
    st_d.clk_prev    = sample_src;
    st_d.sel_prev    = st_q.filt[`CMPF_FILT_SEL_HI:`CMPF_FILT_SEL_LO];
    st_d.result_prev = result;
    if (src_rise)
      st_d.div_cnt = sample_tick ? 7'h00 : st_q.div_cnt + 7'h01;
    // Pin shows result only when enabled and not in amplifier mode
    st_d.pin = result & st_q.ctrl[`CMPF_CTRL_PIN_EN]
             & ~st_q.ctrl[`CMPF_CTRL_AMP];

    // Write address and data taken in either order
    if (s_axi_awvalid && !st_q.aw_got && st_q.wst == cmpf_pkg::CMPF_WR_IDLE)
    begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_got && st_q.wst == cmpf_pkg::CMPF_WR_IDLE)
    begin
      st_d.w_got = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end

    // Both halves held: apply the write, then answer until bready
    case (st_q.wst)
      cmpf_pkg::CMPF_WR_IDLE:
      begin
        if (st_q.aw_got && st_q.w_got)
        begin
          st_d.aw_got = 1'b0;
          st_d.w_got  = 1'b0;
          st_d.bresp  = 2'h0;
          st_d.wst    = cmpf_pkg::CMPF_WR_RESP;
          case (st_q.awaddr)
            `CMPF_OFF_CTRL:
            begin
              if (st_q.wstrb[0])
                st_d.ctrl[7:0] = st_q.wdata[7:0] & 8'(`CMPF_CTRL_WMASK);
              if (st_q.wstrb[1])
              begin
                st_d.ctrl[15:8] = st_q.wdata[15:8] & 8'(`CMPF_CTRL_WMASK >> 8);
                // Event flag: a zero clears it, a one leaves it as it is
                st_d.ctrl[`CMPF_CTRL_EVT] = st_q.ctrl[`CMPF_CTRL_EVT]
                                          & st_q.wdata[`CMPF_CTRL_EVT];
              end
            end
            `CMPF_OFF_FILT:
              if (st_q.wstrb[0])
                st_d.filt[7:0] = st_q.wdata[7:0] & 8'h7F;
            `CMPF_OFF_IRQ_EN:
              if (st_q.wstrb[0])
                st_d.ien = st_q.wdata[`CMPF_IRQ_WIDTH-1:0];
            `CMPF_OFF_IRQ_CLR:
              if (st_q.wstrb[0])
                st_d.stat = st_q.stat & ~st_q.wdata[`CMPF_IRQ_WIDTH-1:0];
            `CMPF_OFF_IRQ_STAT: ;
            // Unmapped: error response, nothing written
            default: st_d.bresp = 2'h2;
          endcase
        end
      end
      cmpf_pkg::CMPF_WR_RESP:
        if (s_axi_bready)
          st_d.wst = cmpf_pkg::CMPF_WR_IDLE;
      default:
        st_d.wst = cmpf_pkg::CMPF_WR_IDLE;
    endcase

    // Hardware set wins over software clear
    if (event_hit)
    begin
      st_d.ctrl[`CMPF_CTRL_EVT]  = 1'b1;
      st_d.stat[`CMPF_IRQ_EVENT] = 1'b1;
    end

    // Read channel
    if (s_axi_arvalid && !st_q.rvalid)
    begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = rd_word;
      st_d.rresp  = rd_ok ? 2'h0 : 2'h2;
    end
    else if (st_q.rvalid && s_axi_rready)
      st_d.rvalid = 1'b0;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      st_q      <= '0;
      st_q.ctrl <= `CMPF_CTRL_RESET;
      st_q.filt <= `CMPF_FILT_RESET;
      st_q.wst  <= cmpf_pkg::CMPF_WR_IDLE;
    end
    else
      st_q <= st_d;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Handshakes come straight from state; data and responses are registered
  assign s_axi_awready = !st_q.aw_got && st_q.wst == cmpf_pkg::CMPF_WR_IDLE;
  assign s_axi_wready  = !st_q.w_got && st_q.wst == cmpf_pkg::CMPF_WR_IDLE;
  assign s_axi_bvalid  = st_q.wst == cmpf_pkg::CMPF_WR_RESP;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;

  // Analog routing controls
  assign unit_on_o                 = st_q.ctrl[`CMPF_CTRL_ON];
  assign amplifier_select_o        = st_q.ctrl[`CMPF_CTRL_AMP];
  assign positive_is_reference_o   = st_q.ctrl[`CMPF_CTRL_REF];
  assign negative_channel_select_o = st_q.ctrl[`CMPF_CTRL_CH_HI:`CMPF_CTRL_CH_LO];
  // Missing inputs tie to ground
  assign positive_grounded_o = st_q.ctrl[`CMPF_CTRL_REF] ? 1'b0
                             : ~input_present_i[0];
  assign negative_grounded_o = ~input_present_i[st_q.ctrl[`CMPF_CTRL_CH_HI:
                               `CMPF_CTRL_CH_LO]];

  // Registered pin value and its active-low drive enable
  assign result_output_pin_o      = st_q.pin;
  assign result_output_pin_oe_n_o = ~(st_q.ctrl[`CMPF_CTRL_PIN_EN]
                                    & ~st_q.ctrl[`CMPF_CTRL_AMP]);
  // Level interrupt while any enabled status bit stands
  assign irq_o = |(st_q.stat & st_q.ien);

endmodule // cmpf_top

`default_nettype wire

//--- dv/cmpf_props.sv
// Checker of the comparator control block: bus handshakes and input routing.
// Assumes it is bound to cmpf_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module cmpf_props (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [3:0]  input_present_i,
  input wire logic        amplifier_select_o,
  input wire logic        positive_is_reference_o,
  input wire logic        positive_grounded_o,
  input wire logic [1:0]  negative_channel_select_o,
  input wire logic        negative_grounded_o,
  input wire logic        result_output_pin_oe_n_o
);
  // ==========================================================================
  // Single clock domain, reset disables every check
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // Input routing and pin drive
  a_neg_ground: assert property (
    negative_grounded_o == !input_present_i[negative_channel_select_o])
    else $error("negative input grounding wrong");
  a_pos_ground: assert property (
    positive_grounded_o == (!positive_is_reference_o && !input_present_i[0]))
    else $error("positive input grounding wrong");
  a_amp_no_pin: assert property (
    amplifier_select_o && $past(amplifier_select_o) |-> result_output_pin_oe_n_o)
    else $error("pin driven in amplifier mode");

  // ==========================================================================
  // Register bus handshakes
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_write_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_block: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule // cmpf_props

bind cmpf_top cmpf_props cmpf_props_i (
  .clock_i, .rst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .input_present_i, .amplifier_select_o,
  .positive_is_reference_o, .positive_grounded_o, .negative_channel_select_o,
  .negative_grounded_o, .result_output_pin_oe_n_o);

`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench of the comparator control and filter block.
// Assumes the design files and cmpf_regs.svh are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "cmpf_regs.svh"

`define CHK(a, e) \
  begin \
    num_checks++; \
    if ((a) !== (e)) \
    begin \
      failures++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, (a), (e)); \
    end \
  end

module tb_top;
  logic clock_i = 1'b0, rst_i = 1'b1, raw = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, src_q = 2'h0, ch_sel;
  logic [3:0]  input_present_i = 4'hF;
  logic unit_on, amp_sel, pos_ref, pos_gnd, neg_gnd, pin, pin_oe_n, irq;
  int failures = 0, num_checks = 0, stall = 0;
  localparam logic [15:0] CTL [5] = '{16'hC000, 16'hC000, 16'hE000, 16'hE000, 16'h4000};
  localparam logic [4:0]  RAWS = 5'b11001;
  localparam logic [4:0]  EXPS = 5'b00101;

  // Clock and sample sources, one source period is four clocks
  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) src_q <= src_q + 2'h1;

  cmpf_top cmpf_top_i (
    .clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .raw_compare_i(raw), .input_present_i(input_present_i),
    .timer_two_clock_i(src_q[1]), .timer_three_clock_i(src_q[1]),
    .timer_four_clock_i(src_q[1]), .timer_five_clock_i(src_q[1]),
    .pwm_sync_output_i(src_q[1]), .oscillator_clock_i(src_q[1]),
    .peripheral_clock_i(src_q[1]), .unit_on_o(unit_on), .amplifier_select_o(amp_sel),
    .positive_is_reference_o(pos_ref), .positive_grounded_o(pos_gnd),
    .negative_channel_select_o(ch_sel), .negative_grounded_o(neg_gnd),
    .result_output_pin_o(pin), .result_output_pin_oe_n_o(pin_oe_n), .irq_o(irq));

  // ==========================================================================
  // Bus master tasks, response channel raised after an optional stall
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    int k = 0;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 99; n++)
    begin
      @(posedge clock_i);
      if (s_axi_bvalid && s_axi_bready)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (!s_axi_awvalid && !s_axi_wvalid && k++ >= stall) s_axi_bready <= 1'b1;
    end
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int k = 0;
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 99; n++)
    begin
      @(posedge clock_i);
      if (s_axi_rvalid && s_axi_rready)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (!s_axi_arvalid && k++ >= stall) s_axi_rready <= 1'b1;
    end
  endtask

  // Pin helpers: wait for a level, or count cycles that leave a level
  task automatic wait_pin(input logic e, input int n);
    for (int i = 0; i < n && pin !== e; i++) @(posedge clock_i);
    `CHK(pin, e)
  endtask

  task automatic hold_pin(input logic e, input int n);
    int bad = 0;
    repeat (n) @(posedge clock_i) bad += (pin !== e);
    `CHK(bad, 0)
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(`CMPF_OFF_CTRL, d, r); `CHK(d, 32'h0)
    rd(`CMPF_OFF_FILT, d, r); `CHK(d, 32'h0)
    `CHK({pin_oe_n, irq, unit_on}, 3'h4)
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    stall = 3;
    wr(`CMPF_OFF_CTRL, 32'hFFFF_5FFF, r);
    rd(`CMPF_OFF_CTRL, d, r); `CHK(d, 32'h44D3)
    `CHK({pin_oe_n, amp_sel}, 2'h3)
    wr(`CMPF_OFF_FILT, 32'hFFFF_FFFF, r);
    rd(`CMPF_OFF_FILT, d, r); `CHK(d, 32'h7F)
    wr(5'h14, 32'h1, r); `CHK(r, 2'h2)
    rd(5'h14, d, r); `CHK(r, 2'h2)
    rd(`CMPF_OFF_IRQ_CLR, d, r); `CHK(d, 32'h0)
    stall = 0;
  endtask

  task automatic t_route;
    logic [1:0] r;
    for (int c = 0; c < 4; c++)
    begin
      input_present_i <= 4'hF ^ (4'h1 << c);
      wr(`CMPF_OFF_CTRL, 32'(c), r);
      @(posedge clock_i);
      `CHK({ch_sel, neg_gnd}, {2'(c), 1'b1})
      `CHK(pos_gnd, c == 0)
      wr(`CMPF_OFF_CTRL, 32'(c) | 32'h10, r);
      @(posedge clock_i);
      `CHK({pos_ref, pos_gnd}, 2'h2)
    end
    input_present_i <= 4'hF;
  endtask

  task automatic t_result;
    logic [31:0] d;
    logic [1:0] r;
    wr(`CMPF_OFF_FILT, 32'h0, r);
    for (int i = 0; i < 5; i++)
    begin
      raw <= RAWS[i];
      wr(`CMPF_OFF_CTRL, {16'h0, CTL[i]}, r);
      wait_pin(EXPS[i], 20);
      hold_pin(EXPS[i], 6);
      `CHK(unit_on, CTL[i][15])
      rd(`CMPF_OFF_CTRL, d, r); `CHK(d[8], EXPS[i])
      `CHK(pin_oe_n, 1'b0)
    end
    wr(`CMPF_OFF_CTRL, 32'h8000, r);
    @(posedge clock_i);
    `CHK(pin_oe_n, 1'b1)
  endtask

  task automatic t_event;
    logic [31:0] d;
    logic [1:0] r;
    for (int p = 0; p < 4; p++)
    begin
      raw <= 1'b0;
      wr(`CMPF_OFF_CTRL, 32'h8000 | 32'(p << 6), r);
      wr(`CMPF_OFF_IRQ_CLR, 32'h1, r);
      wr(`CMPF_OFF_IRQ_EN, 32'h1, r);
      repeat (8) @(posedge clock_i);
      raw <= 1'b1;
      repeat (8) @(posedge clock_i);
      `CHK(irq, p[0])
      wr(`CMPF_OFF_IRQ_CLR, 32'h1, r);
      raw <= 1'b0;
      repeat (8) @(posedge clock_i);
      rd(`CMPF_OFF_IRQ_STAT, d, r); `CHK(d[0], p[1] & ~p[0])
      rd(`CMPF_OFF_CTRL, d, r); `CHK(d[9], p[0] | p[1])
      wr(`CMPF_OFF_IRQ_EN, 32'h0, r);
      @(posedge clock_i);
      `CHK(irq, 1'b0)
    end
  endtask

  task automatic t_filter;
    logic [1:0] r;
    wr(`CMPF_OFF_CTRL, 32'hC000, r);
    wr(`CMPF_OFF_FILT, 32'h38, r);
    raw <= 1'b1;
    hold_pin(1'b0, 100);
    for (int s = 0; s < 8; s++)
    begin
      if (s == 3) continue;
      // Level alternates so that every code but the reserved one must move the pin
      raw <= s[0] ^ (s < 4);
      wr(`CMPF_OFF_FILT, 32'(s << 4) | 32'h8, r);
      wait_pin(s[0] ^ (s < 4), 60);
    end
    @(posedge clock_i) raw <= 1'b0;
    @(posedge clock_i) raw <= 1'b1;
    hold_pin(1'b1, 40);
    for (int v = 0; v < 8; v++)
    begin
      wr(`CMPF_OFF_FILT, 32'h8 | 32'(v), r);
      raw <= v[0];
      hold_pin(~v[0], 8 << v);
      wait_pin(v[0], 20 << v);
    end
  endtask

  // ==========================================================================
  // Verdict, main sequence and watchdog
  task automatic give_verdict;
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_route();
    t_result();
    t_event();
    t_filter();
    give_verdict();
  end

  initial
  begin
    repeat (40000) @(posedge clock_i);
    failures++;
    give_verdict();
  end
endmodule // tb_top

`default_nettype wire
